// *** test/lpmc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bench commands
  input wire logic sleep_cmd,
  input wire logic irq_cmd,
  // Block side
  input wire logic cpu_clk_en,
  output logic core_wfi,
  output logic periph_irq
);
  //////////////////////////////////////////////////////////////////////////
  // Core sleeps only while clocked; interrupt held until it runs again
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_wfi <= 1'b0;
      periph_irq <= 1'b0;
    end
    else
    begin
      core_wfi <= sleep_cmd & cpu_clk_en;
      periph_irq <= irq_cmd & ~cpu_clk_en;
    end
  end
endmodule
`default_nettype wire

// *** test/test_low_power_mode_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_controller;
  logic ref_clk = 1'b0;
  logic reset_n, reg_wr, reg_rd, irq, core_wfi, periph_irq, rd_q;
  logic sleep_cmd, irq_cmd, ext_n, wdg, vdd, vref, hsi_req, flash_ws;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, m;
  logic [2:0] pin;
  logic [1:0] vos_range;
  logic [15:0] cpu_freq_khz;
  lpmc_pkg::lpmc_wake_t wake_src;
  lpmc_pkg::lpmc_pwr_t pwr;
  logic [31:0] exp_q [$];
  int num_errors = 0;
  int checked = 0;
  int c;
  logic [7:0] sa [5] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
  logic [31:0] sd [5] = '{32'h41, 32'h3E80, 32'h4E20, 32'h42, 32'h43};
  logic [1:0] sr [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [15:0] sf [5] = '{16'h834, 16'h3E80, 16'h4E20, 16'h3E80, 16'h1068};
  logic sw [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always #5 ref_clk = ~ref_clk;

  lpmc_ctrl #(.STBY_EXIT_CYC(20)) u_lpmc_ctrl (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .core_wfi(core_wfi),
    .periph_irq(periph_irq), .wake_src(wake_src), .wakeup_pin(pin),
    .external_reset_pin_n(ext_n), .watchdog_reset(wdg),
    .vdd_ge_171(vdd), .vref_on(vref), .hsi_req(hsi_req), .pwr(pwr),
    .vos_range(vos_range), .flash_ws(flash_ws),
    .cpu_freq_khz(cpu_freq_khz));

  lpmc_core_model u_lpmc_core_model (
    .ref_clk(ref_clk), .reset_n(reset_n), .sleep_cmd(sleep_cmd),
    .irq_cmd(irq_cmd), .cpu_clk_en(pwr.cpu_clk_en),
    .core_wfi(core_wfi), .periph_irq(periph_irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] e, input logic [31:0] s,
                     input string n);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // Read data stands the cycle after the read edge
  always @(posedge ref_clk) rd_q <= reg_rd;
  always @(negedge ref_clk)
    if (rd_q && exp_q.size() > 0)
      chk(exp_q.pop_front(), reg_rdata, "reg_rdata");

  task automatic finish_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wait_cpu(input int n);
    for (c = 1; c <= n; c++)
    begin
      @(negedge ref_clk);
      if (pwr.cpu_clk_en === 1'b1)
        break;
    end
    if (c > n)
    begin
      num_errors++;
      $display("BAD cpu_clk_en expected 1 seen %b", pwr.cpu_clk_en);
      finish_test;
    end
  endtask

  task automatic enter(input logic [2:0] md);
    wr(8'h00, 32'h843 | (md << 2));
    @(posedge ref_clk);
    sleep_cmd <= 1'b1;
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
    idle(2);
  endtask

  task automatic wake_irq;
    @(posedge ref_clk);
    irq_cmd <= 1'b1;
    wait_cpu(10);
    @(posedge ref_clk);
    irq_cmd <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_n, reg_wr, reg_rd, sleep_cmd, irq_cmd, wdg, vref, hsi_req} = '0;
    {ext_n, vdd} = 2'h3;
    reg_addr = '0;
    reg_wdata = '0;
    pin = '0;
    wake_src = '0;
    void'($urandom(32'h5BF9));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(4);
    rd(8'h00, 32'h42);
    rd(8'h04, 32'h834);
    rd(8'hFC, 32'h0);
    m = $urandom & 32'hF;
    wr(8'h0C, m);
    rd(8'h0C, m);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      wr(sa[i], sd[i]);
      idle(3);
      chk(sr[i], vos_range, "vos_range");
      chk(sf[i], cpu_freq_khz, "cpu_freq_khz");
      chk(sw[i], flash_ws, "flash_ws");
      idle(510);
    end
    @(posedge ref_clk);
    vdd <= 1'b0;
    idle(4);
    wr(8'h00, 32'h41);
    idle(2);
    chk(3, vos_range, "vos_range");
    rd(8'h08, 32'h4);
    @(posedge ref_clk);
    vdd <= 1'b1;
    $display("test range done");
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h863);
    idle(3);
    chk(1, pwr.reg_lp & pwr.msi_low_speed, "lp_run");
    chk(1, cpu_freq_khz <= 16'h0083, "lp_freq");
    enter(3'h1);
    chk(0, pwr.cpu_clk_en, "lp_sleep_cpu");
    chk(1, pwr.reg_lp, "lp_sleep_reg");
    wake_irq;
    chk(0, pwr.reg_lp, "lp_wake_reg");
    enter(3'h0);
    chk(2'h1, {pwr.cpu_clk_en, pwr.periph_clk_en}, "sleep");
    wake_irq;
    $display("test sleep done");
    enter(3'h2);
    chk(0, {pwr.pll_en, pwr.multispeed_osc_en, pwr.fast_internal_osc_en,
            pwr.fast_crystal_osc_en}, "stop_fast");
    chk(3'h7, {pwr.slow_internal_osc_en, pwr.retain, pwr.reg_lp},
        "stop_keep");
    chk(2'h3, {pwr.rtc_run, pwr.lcd_run}, "stop_rtc_lcd");
    @(posedge ref_clk);
    hsi_req <= 1'b1;
    idle(4);
    chk(1, pwr.fast_internal_osc_en, "hsi_req");
    @(posedge ref_clk);
    hsi_req <= 1'b0;
    wake_src.rtc_evt <= 1'b1;
    wait_cpu(400);
    chk(1, irq, "irq_set");
    rd(8'h08, 32'h1);
    idle(2);
    chk(0, irq, "irq_clear");
    enter(3'h3);
    chk(3'h1, {pwr.slow_crystal_osc_en, pwr.slow_internal_osc_en,
               pwr.retain}, "stop_all");
    @(posedge ref_clk);
    wake_src.comp1 <= 1'b1;
    idle(8);
    chk(0, pwr.multispeed_osc_en, "stop_ignore");
    @(posedge ref_clk);
    wake_src <= '0;
    @(posedge ref_clk);
    wake_src.gpio <= 1'b1;
    wait_cpu(400);
    chk(1, c >= 350 && c <= 356, "stop_wake_time");
    @(posedge ref_clk);
    wake_src <= '0;
    rd(8'h08, 32'h1);
    $display("test stop done");
    for (int k = 0; k < 2; k++)
    begin
      enter(k ? 3'h5 : 3'h4);
      chk(3'h6, {pwr.reg_off, pwr.core_reset, pwr.core_pwr_on},
          "standby");
      if (k)
      begin
        @(posedge ref_clk);
        wdg <= 1'b1;
        wake_src.rtc_evt <= 1'b1;
        idle(30);
        chk(1, pwr.core_reset, "stby_ignore");
        @(posedge ref_clk);
        wdg <= 1'b0;
        wake_src <= '0;
        pin <= 3'h4;
      end
      else
      begin
        @(posedge ref_clk);
        wdg <= 1'b1;
      end
      wait_cpu(40);
      chk(1, c <= 26, "stby_exit_time");
      @(posedge ref_clk);
      wdg <= 1'b0;
      pin <= '0;
      rd(8'h00, 32'h42);
      rd(8'h08, 32'h8);
    end
    $display("test standby done");
    finish_test;
  end
endmodule
`default_nettype wire

// *** verilog/lpmc_ctrl.sv ***
// Functional notes
// - Cap CPU clock per voltage scaling range.
// - One flash wait state above range limit.
// - Sleep stops CPU only; interrupts wake.
// - Low-power run: low-speed multispeed, regulator low.
// - Low-power sleep wakes to Run, regulator on.
// - Stop with clock: fast clocks off, retain.
// - Stop without clock: all clocks off, retain.
// - Peripherals may request fast internal oscillator.
// - Event lines wake Stop within 3.5 us.
// - Stop wake sources; comparators need reference.
// - Standby: regulator off, core state lost.
// - Standby with clock: six exit causes, 60 us.
// - Standby without clock: reset or pin only.
// - Stop/Standby with clock keep clock, watchdog; display runs in Stop only.
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl #(
  parameter int unsigned STBY_EXIT_CYC = lpmc_pkg::STBY_EXIT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Core side
  input wire logic core_wfi,
  input wire logic periph_irq,
  // Wakeup sources, asynchronous
  input wire lpmc_pkg::lpmc_wake_t wake_src,
  input wire logic [2:0] wakeup_pin,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic vdd_ge_171,
  input wire logic vref_on,
  input wire logic hsi_req,
  // Power and clock controls
  output lpmc_pkg::lpmc_pwr_t pwr,
  output logic [1:0] vos_range,
  output logic flash_ws,
  output logic [15:0] cpu_freq_khz
);

  typedef struct packed {
    lpmc_pkg::lpmc_state_t st;
    lpmc_pkg::lpmc_ctrl_t ctrl;
    logic [15:0] freq;
    logic [15:0] eff;
    logic ws;
    lpmc_pkg::lpmc_stat_t stat;
    lpmc_pkg::lpmc_stat_t mask;
    logic keep_rtc;
    logic [2:0] pin_q;
    logic [31:0] rdata;
    lpmc_pkg::lpmc_pwr_t pwr;
  } lpmc_ctrl_st_t;

  lpmc_ctrl_st_t q;
  lpmc_ctrl_st_t next_q;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and timers
  logic [17:0] sync_out;
  lpmc_pkg::lpmc_wake_t ws_s;
  logic [2:0] pin_s;
  logic ext_rst_n_s;
  logic wdg_s;
  logic vdd_ok_s;
  logic vref_s;
  logic hsi_req_s;

  lpmc_sync #(.W(18)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .d({wake_src, wakeup_pin, external_reset_pin_n, watchdog_reset,
        vdd_ge_171, vref_on, hsi_req}),
    .q_sync(sync_out)
  );

  assign {ws_s, pin_s, ext_rst_n_s, wdg_s, vdd_ok_s, vref_s, hsi_req_s} =
    sync_out;

  logic wake_start;
  logic wake_done;
  logic gap_start;
  logic gap_busy;
  logic stby_start;
  logic stby_done;

  lpmc_delay #(.W(lpmc_pkg::TMR_W), .CYC(lpmc_pkg::STOP_WAKE_CYC)) u_wake (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(wake_start),
    .busy(),
    .done(wake_done)
  );

  lpmc_delay #(.W(lpmc_pkg::TMR_W), .CYC(lpmc_pkg::FREQ_GAP_CYC)) u_gap (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(gap_start),
    .busy(gap_busy),
    .done()
  );

  lpmc_delay #(.W(lpmc_pkg::TMR_W), .CYC(STBY_EXIT_CYC)) u_stby (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(stby_start),
    .busy(),
    .done(stby_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup qualification
  logic stop_wake;
  logic stby_wake;
  logic pin_rise;

  assign pin_rise = |(pin_s & ~q.pin_q);
  assign stop_wake = ws_s.gpio | ws_s.voltage_detector_out | ws_s.usb | ws_s.usart |
                     ws_s.i2c | ws_s.low_power_uart | ws_s.lptim |
                     ((ws_s.comp1 | ws_s.comp2) & vref_s) |
                     (ws_s.rtc_evt & q.keep_rtc);
  assign stby_wake = !ext_rst_n_s | pin_rise |
                     (q.keep_rtc & (wdg_s | ws_s.rtc_evt));

  assign gap_start = reg_wr && (reg_addr == lpmc_pkg::OFS_FREQ);
  assign wake_start = (q.st == lpmc_pkg::ST_STOP) && stop_wake;
  assign stby_start = (q.st == lpmc_pkg::ST_STBY) && stby_wake;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic [15:0] wfreq;
  logic [17:0] four_new;

  always_comb
  begin
    next_q = q;
    next_q.pin_q = pin_s;
    next_q.rdata = '0;
    wfreq = reg_wdata[15:0];
    four_new = {wfreq, 2'b00};

    // Register reads, status cleared by its read
    if (reg_rd)
    begin
      unique case (reg_addr)
        lpmc_pkg::OFS_CTRL: next_q.rdata = {20'h00000, q.ctrl};
        lpmc_pkg::OFS_FREQ: next_q.rdata = {16'h0000, q.freq};
        lpmc_pkg::OFS_STAT:
        begin
          next_q.rdata = {28'h0000000, q.stat};
          next_q.stat = '0;
        end
        lpmc_pkg::OFS_MASK: next_q.rdata = {28'h0000000, q.mask};
        lpmc_pkg::OFS_STATE:
          next_q.rdata = {q.eff, 8'h00, vdd_ok_s, q.keep_rtc, q.ws,
                          q.st, q.ctrl.range};
        default: next_q.rdata = '0;
      endcase
    end

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        lpmc_pkg::OFS_CTRL:
        begin
          next_q.ctrl = reg_wdata[11:0];
          if (reg_wdata[1:0] == 2'h0 ||
              (reg_wdata[1:0] == lpmc_pkg::RANGE_1 && !vdd_ok_s))
          begin
            next_q.ctrl.range = q.ctrl.range;
            next_q.stat.range_err = 1'b1;
          end
        end
        lpmc_pkg::OFS_FREQ:
        begin
          next_q.freq = wfreq;
          if (wfreq > lpmc_pkg::freq_cap(next_q.ctrl.range))
            next_q.stat.freq_err = 1'b1;
          if (gap_busy || !({2'b00, q.eff} < four_new))
            next_q.stat.freq_err = 1'b1;
        end
        lpmc_pkg::OFS_MASK: next_q.mask = reg_wdata[3:0];
        default: next_q.mask = next_q.mask;
      endcase
    end

    // Supply sag forces range two
    if (!vdd_ok_s && next_q.ctrl.range == lpmc_pkg::RANGE_1)
    begin
      next_q.ctrl.range = lpmc_pkg::RANGE_2;
      next_q.stat.range_err = 1'b1;
    end

    // Mode sequencing
    unique case (q.st)
      lpmc_pkg::ST_RUN, lpmc_pkg::ST_LPRUN:
      begin
        if (core_wfi)
        begin
          unique case (q.ctrl.mode)
            lpmc_pkg::MODE_LPSLEEP: next_q.st = lpmc_pkg::ST_LPSLEEP;
            lpmc_pkg::MODE_STOP_RTC, lpmc_pkg::MODE_STOP:
              next_q.st = lpmc_pkg::ST_STOP;
            lpmc_pkg::MODE_STBY_RTC, lpmc_pkg::MODE_STBY:
              next_q.st = lpmc_pkg::ST_STBY;
            default: next_q.st = (q.st == lpmc_pkg::ST_LPRUN) ?
                       lpmc_pkg::ST_LPSLEEP : lpmc_pkg::ST_SLEEP;
          endcase
          next_q.keep_rtc = (q.ctrl.mode == lpmc_pkg::MODE_STOP_RTC) ||
                            (q.ctrl.mode == lpmc_pkg::MODE_STBY_RTC);
        end
        else
          next_q.st = q.ctrl.lp_run ? lpmc_pkg::ST_LPRUN :
                      lpmc_pkg::ST_RUN;
      end
      lpmc_pkg::ST_SLEEP, lpmc_pkg::ST_LPSLEEP:
        if (periph_irq)
          next_q.st = lpmc_pkg::ST_RUN;
      lpmc_pkg::ST_STOP:
        if (stop_wake)
          next_q.st = lpmc_pkg::ST_WAKE;
      lpmc_pkg::ST_WAKE:
        if (wake_done)
        begin
          next_q.st = lpmc_pkg::ST_RUN;
          next_q.stat.wake = 1'b1;
        end
      lpmc_pkg::ST_STBY:
        if (stby_wake)
          next_q.st = lpmc_pkg::ST_STBY_EXIT;
      lpmc_pkg::ST_STBY_EXIT:
        if (stby_done)
        begin
          // Core state was not retained: defaults come back
          next_q.st = lpmc_pkg::ST_RUN;
          next_q.ctrl = lpmc_pkg::CTRL_RST;
          next_q.freq = lpmc_pkg::FREQ_RST;
          next_q.mask = '0;
          next_q.stat.stby_exit = 1'b1;
        end
    endcase
    if (!vdd_ok_s && next_q.ctrl.range == lpmc_pkg::RANGE_1)
      next_q.ctrl.range = lpmc_pkg::RANGE_2;

    // Effective clock and flash wait states
    next_q.eff = next_q.freq;
    if (next_q.eff > lpmc_pkg::freq_cap(next_q.ctrl.range))
      next_q.eff = lpmc_pkg::freq_cap(next_q.ctrl.range);
    if (next_q.st == lpmc_pkg::ST_LPRUN &&
        next_q.eff > lpmc_pkg::F_LP_MAX)
      next_q.eff = lpmc_pkg::F_LP_MAX;
    next_q.ws = lpmc_pkg::wait_state(next_q.ctrl.range, next_q.eff);

    // Power and clock controls per mode
    next_q.pwr = '0;
    next_q.pwr.core_pwr_on = 1'b1;
    next_q.pwr.retain = 1'b1;
    next_q.pwr.lcd_run = 1'b1;
    next_q.pwr.slow_crystal_osc_en = next_q.ctrl.lse_en;
    next_q.pwr.slow_internal_osc_en = next_q.ctrl.lsi_en;
    next_q.pwr.rtc_run = next_q.ctrl.lse_en | next_q.ctrl.lsi_en;
    unique case (next_q.st)
      lpmc_pkg::ST_RUN, lpmc_pkg::ST_SLEEP:
      begin
        next_q.pwr.cpu_clk_en = (next_q.st == lpmc_pkg::ST_RUN);
        next_q.pwr.periph_clk_en = 1'b1;
        next_q.pwr.pll_en = next_q.ctrl.pll_en;
        next_q.pwr.multispeed_osc_en = next_q.ctrl.msi_en;
        next_q.pwr.fast_internal_osc_en = next_q.ctrl.hsi_en;
        next_q.pwr.fast_crystal_osc_en = next_q.ctrl.hse_en;
      end
      lpmc_pkg::ST_LPRUN, lpmc_pkg::ST_LPSLEEP:
      begin
        next_q.pwr.cpu_clk_en = (next_q.st == lpmc_pkg::ST_LPRUN);
        next_q.pwr.periph_clk_en = 1'b1;
        next_q.pwr.multispeed_osc_en = 1'b1;
        next_q.pwr.msi_low_speed = 1'b1;
        next_q.pwr.reg_lp = 1'b1;
      end
      lpmc_pkg::ST_STOP, lpmc_pkg::ST_WAKE:
      begin
        next_q.pwr.reg_lp = 1'b1;
        next_q.pwr.fast_internal_osc_en = hsi_req_s;
        next_q.pwr.multispeed_osc_en = (next_q.st == lpmc_pkg::ST_WAKE);
        if (!next_q.keep_rtc)
        begin
          next_q.pwr.slow_crystal_osc_en = 1'b0;
          next_q.pwr.slow_internal_osc_en = 1'b0;
          next_q.pwr.rtc_run = 1'b0;
        end
      end
      lpmc_pkg::ST_STBY, lpmc_pkg::ST_STBY_EXIT:
      begin
        next_q.pwr.reg_off = (next_q.st == lpmc_pkg::ST_STBY);
        next_q.pwr.core_pwr_on = (next_q.st == lpmc_pkg::ST_STBY_EXIT);
        next_q.pwr.retain = 1'b0;
        next_q.pwr.lcd_run = 1'b0;
        next_q.pwr.core_reset = 1'b1;
        if (!next_q.keep_rtc)
        begin
          next_q.pwr.slow_crystal_osc_en = 1'b0;
          next_q.pwr.slow_internal_osc_en = 1'b0;
          next_q.pwr.rtc_run = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= lpmc_pkg::ST_RUN;
      q.ctrl <= lpmc_pkg::CTRL_RST;
      q.freq <= lpmc_pkg::FREQ_RST;
      q.eff <= lpmc_pkg::FREQ_RST;
      q.pwr.core_pwr_on <= 1'b1;
      q.pwr.retain <= 1'b1;
    end
    else
      q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = q.rdata;
  assign irq = |(q.stat & q.mask);
  assign pwr = q.pwr;
  assign vos_range = q.ctrl.range;
  assign flash_ws = q.ws;
  assign cpu_freq_khz = q.eff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int WAKE_MAX = lpmc_pkg::STOP_WAKE_CYC;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_CAP: assert property (
    q.eff <= lpmc_pkg::freq_cap(q.ctrl.range))
    else $error("cpu clock above range cap");
  AST_WS: assert property (
    q.ws == ((q.ctrl.range == lpmc_pkg::RANGE_1 && q.eff > 16'h3E80) ||
             (q.ctrl.range == lpmc_pkg::RANGE_2 && q.eff > 16'h1F40)))
    else $error("flash wait state wrong");
  AST_SLEEP_WAKE: assert property (
    q.st == lpmc_pkg::ST_SLEEP && periph_irq
    |=> q.st == lpmc_pkg::ST_RUN && pwr.cpu_clk_en)
    else $error("sleep did not wake on interrupt");
  AST_LPRUN: assert property (
    q.st == lpmc_pkg::ST_LPRUN
    |-> q.eff <= 16'h0083 && pwr.reg_lp && pwr.msi_low_speed)
    else $error("low-power run settings wrong");
  AST_LPSLEEP_EXIT: assert property (
    q.st == lpmc_pkg::ST_LPSLEEP && periph_irq |=> !pwr.reg_lp)
    else $error("regulator not restored after low-power sleep");
  AST_STOP_CLOCKS: assert property (
    q.st == lpmc_pkg::ST_STOP
    |-> !pwr.pll_en && !pwr.multispeed_osc_en && !pwr.fast_crystal_osc_en
        && !pwr.cpu_clk_en && pwr.reg_lp && pwr.retain)
    else $error("stop clock gating wrong");
  AST_STOP_NORTC: assert property (
    q.st == lpmc_pkg::ST_STOP && !q.keep_rtc
    |-> !pwr.slow_crystal_osc_en && !pwr.slow_internal_osc_en)
    else $error("slow oscillator running in stop without clock");
  AST_HSI_REQ: assert property (
    q.st == lpmc_pkg::ST_STOP && $past(q.st) == lpmc_pkg::ST_STOP
    |-> pwr.fast_internal_osc_en == $past(hsi_req_s))
    else $error("fast internal request not honoured");
  AST_STOP_WAKE: assert property (
    $rose(q.st == lpmc_pkg::ST_WAKE)
    |-> ##[1:WAKE_MAX] q.st == lpmc_pkg::ST_RUN)
    else $error("stop wakeup too slow");
  AST_STBY_PWR: assert property (
    q.st == lpmc_pkg::ST_STBY |-> pwr.reg_off && !pwr.core_pwr_on)
    else $error("standby power state wrong");
  AST_STBY_NORTC: assert property (
    q.st == lpmc_pkg::ST_STBY && !q.keep_rtc && ext_rst_n_s && !pin_rise
    |=> q.st == lpmc_pkg::ST_STBY)
    else $error("standby left without valid cause");
  AST_RANGE: assert property (
    !vdd_ok_s |=> q.ctrl.range != lpmc_pkg::RANGE_1)
    else $error("range one with low supply");
  AST_STBY_RST: assert property (
    q.st == lpmc_pkg::ST_STBY_EXIT |-> pwr.core_reset)
    else $error("core not held in reset on standby exit");

endmodule
`default_nettype wire

// *** verilog/lpmc_delay.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpmc_delay #(
  parameter int unsigned W = 13,
  parameter int unsigned CYC = 350
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } lpmc_delay_st_t;

  lpmc_delay_st_t q;
  lpmc_delay_st_t next_q;

  // Done pulses exactly CYC edges after start
  always_comb
  begin
    next_q = q;
    if (start)
      next_q.cnt = W'(CYC);
    else if (q.cnt != '0)
      next_q.cnt = q.cnt - W'(1);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign busy = (q.cnt != '0);
  assign done = (q.cnt == W'(1));

endmodule
`default_nettype wire

// *** verilog/lpmc_pkg.sv ***
`default_nettype none
package lpmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STOP_WAKE_NS = 3500;
  localparam int unsigned STOP_WAKE_CYC = STOP_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned FREQ_GAP_NS = 5000;
  localparam int unsigned FREQ_GAP_CYC =
    (FREQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STBY_EXIT_NS = 60000;
  localparam int unsigned STBY_EXIT_CYC = STBY_EXIT_NS / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;

  localparam logic [1:0] RANGE_1 = 2'h1;
  localparam logic [1:0] RANGE_2 = 2'h2;
  localparam logic [1:0] RANGE_3 = 2'h3;

  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_LPSLEEP = 3'h1;
  localparam logic [2:0] MODE_STOP_RTC = 3'h2;
  localparam logic [2:0] MODE_STOP = 3'h3;
  localparam logic [2:0] MODE_STBY_RTC = 3'h4;
  localparam logic [2:0] MODE_STBY = 3'h5;

  // Frequencies in kHz
  localparam logic [15:0] F_R1_MAX = 16'h7D00;
  localparam logic [15:0] F_R2_MAX = 16'h3E80;
  localparam logic [15:0] F_R3_MAX = 16'h1068;
  localparam logic [15:0] F_R1_WS = 16'h3E80;
  localparam logic [15:0] F_R2_WS = 16'h1F40;
  localparam logic [15:0] F_LP_MAX = 16'h0083;

  typedef struct packed {
    logic lsi_en;
    logic lse_en;
    logic pll_en;
    logic hse_en;
    logic hsi_en;
    logic msi_en;
    logic lp_run;
    logic [2:0] mode;
    logic [1:0] range;
  } lpmc_ctrl_t;

  localparam lpmc_ctrl_t CTRL_RST = 12'h042;
  localparam logic [15:0] FREQ_RST = 16'h0834;

  typedef struct packed {
    logic stby_exit;
    logic range_err;
    logic freq_err;
    logic wake;
  } lpmc_stat_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SLEEP = 3'h1,
    ST_LPRUN = 3'h3,
    ST_LPSLEEP = 3'h2,
    ST_STOP = 3'h6,
    ST_WAKE = 3'h7,
    ST_STBY = 3'h5,
    ST_STBY_EXIT = 3'h4
  } lpmc_state_t;

  typedef struct packed {
    logic rtc_evt;
    logic lptim;
    logic low_power_uart;
    logic i2c;
    logic usart;
    logic usb;
    logic comp2;
    logic comp1;
    logic voltage_detector_out;
    logic gpio;
  } lpmc_wake_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic pll_en;
    logic multispeed_osc_en;
    logic msi_low_speed;
    logic fast_internal_osc_en;
    logic fast_crystal_osc_en;
    logic slow_crystal_osc_en;
    logic slow_internal_osc_en;
    logic reg_lp;
    logic reg_off;
    logic core_pwr_on;
    logic retain;
    logic core_reset;
    logic lcd_run;
    logic rtc_run;
  } lpmc_pwr_t;

  function automatic logic [15:0] freq_cap(input logic [1:0] range);
    freq_cap = (range == RANGE_1) ? F_R1_MAX :
               (range == RANGE_2) ? F_R2_MAX : F_R3_MAX;
  endfunction

  function automatic logic wait_state(input logic [1:0] range,
                                      input logic [15:0] f);
    wait_state = (range == RANGE_1) ? (f > F_R1_WS) :
                 (range == RANGE_2) ? (f > F_R2_WS) : 1'b0;
  endfunction

endpackage
`default_nettype wire

// *** verilog/lpmc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lpmc_sync_st_t;

  lpmc_sync_st_t q;
  lpmc_sync_st_t next_q;

  always_comb
  begin
    next_q.s1 = d;
    next_q.s2 = q.s1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign q_sync = q.s2;

endmodule
`default_nettype wire
